// *** common/eeprom_front_pkg.sv ***
// Constants and carrier types for the two-wire EEPROM slave front end
`default_nettype none
package eeprom_front_pkg;
    // Memory-class type code; value arbitrary, top bit kept set
    localparam logic [3:0]  TYPE_CODE      = 4'h9;
    localparam int          ADDR_BITS      = 14;
    localparam int          HI_USED_BITS   = 6;
    localparam int          DIR_BIT        = 0;
    localparam int          UNIT_LSB       = 1;
    localparam int          TYPE_LSB       = 4;
    localparam logic [3:0]  ACK_SLOT       = 4'h8;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          WR_TIME_MS     = 6;
    localparam int          WR_CYCLES      = WR_TIME_MS * 1000000 / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SLAVE,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_WDATA,
        ST_RDATA
    } phase_type;

    typedef struct packed {
        logic [ADDR_BITS-1:0] addr;
        logic [7:0]           data;
        logic                 valid;
    } wr_req_type;

    typedef struct packed {
        logic o;
        logic oe;
    } od_pin_type;
endpackage
`default_nettype wire

// *** hdl/pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_nrst,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_r;

    // Reset level 1 matches the idle released bus
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '1;
            o_sync <= '1;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

// *** hdl/eeprom_front.sv ***
// Two-wire serial EEPROM bus slave front end
//
// What this block does
// - Slave address: type, unit select, direction.
// - Match type field against memory class code.
// - Unit select must equal the three straps.
// - Direction bit one reads, zero writes.
// - Receiver pulls data low on ninth clock.
// - Acknowledge each received byte unless ending.
// - First address byte is upper eight bits.
// - Second address byte is lower eight bits.
// - Use low six high bits, all low.
// - Data pin only pulled low or released.
// - Master clocks everything; device is slave.
// - Data changes only while clock low.
// - Falling data, clock high, is start.
// - Rising data, clock high, is stop.
// - Write protect: no data acknowledge, no write.
// - Write protect defaults low when unconnected.
// - Busy after write: released, no acknowledge.
`default_nettype none
module eeprom_front #(
    parameter int WR_CYCLES = eeprom_front_pkg::WR_CYCLES
) (
    // Clock and reset
    input  wire logic                                  i_sys_clk,
    input  wire logic                                  i_nrst,
    // Bus pins
    input  wire logic                                  i_scl,
    input  wire logic                                  i_sda,
    output logic                                       o_sda_o,
    output logic                                       o_sda_oe,
    // Straps and protection
    input  wire logic                                  i_unit_select_strap_hi,
    input  wire logic                                  i_unit_select_strap_mid,
    input  wire logic                                  i_unit_select_strap_lo,
    input  wire logic                                  i_write_protect,
    // Memory side
    input  wire logic [7:0]                            i_rd_data,
    output logic      [eeprom_front_pkg::ADDR_BITS-1:0] o_addr,
    output logic      [7:0]                            o_wr_data,
    output logic                                       o_wr_strobe,
    output logic                                       o_busy,
    output logic                                       o_selected
);
    ////////////////////////////////////////////////////////////////////////////
    // Synchronised pins
    logic [5:0] sync_in;
    logic [5:0] sync_out;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic       scl_d_r;
    logic       sda_d_r;

    // Pull-down: a floating protect pin is modelled low by the pad
    // Straps are pins too, so they pass the same two flops
    assign sync_in = {i_scl, i_sda, i_write_protect, i_unit_select_strap_hi,
                      i_unit_select_strap_mid, i_unit_select_strap_lo};

    pin_sync #(.W(6)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_async   (sync_in),
        .o_sync    (sync_out)
    );

    assign scl_s = sync_out[5];
    assign sda_s = sync_out[4];
    assign wp_s  = sync_out[3];

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge and condition decode
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // State
    eeprom_front_pkg::phase_type          phase_r;
    eeprom_front_pkg::phase_type          phase_nxt;
    logic [3:0]                           bit_cnt_r;
    logic [7:0]                           shift_r;
    logic                                 ack_r;
    logic                                 tx_r;
    logic                                 mack_r;
    logic [eeprom_front_pkg::ADDR_BITS-1:0] addr_r;
    logic [7:0]                           hi_r;
    eeprom_front_pkg::wr_req_type         wr_r;
    logic                                 pend_r;
    logic [31:0]                          busy_cnt_r;

    wire busy = busy_cnt_r != 32'h0;

    // Address decode of a full received slave byte
    wire [7:0] rx_byte = shift_r;
    wire [2:0] straps  = sync_out[2:0];
    wire type_ok = rx_byte[7:eeprom_front_pkg::TYPE_LSB]
                   == eeprom_front_pkg::TYPE_CODE;
    wire unit_ok = rx_byte[eeprom_front_pkg::TYPE_LSB-1:eeprom_front_pkg::UNIT_LSB]
                   == straps;
    wire is_read = rx_byte[eeprom_front_pkg::DIR_BIT];
    wire addr_match = type_ok & unit_ok & ~busy;

    wire byte_done = scl_fall & (bit_cnt_r == eeprom_front_pkg::BITS_PER_BYTE);
    wire slot_done = scl_fall & (bit_cnt_r == eeprom_front_pkg::ACK_SLOT + 4'h1);
    wire rx_phase  = (phase_r == eeprom_front_pkg::ST_SLAVE)
                   | (phase_r == eeprom_front_pkg::ST_ADDR_HI)
                   | (phase_r == eeprom_front_pkg::ST_ADDR_LO)
                   | (phase_r == eeprom_front_pkg::ST_WDATA);

    // Acknowledge decision per phase
    logic ack_want;
    always_comb begin
        ack_want = 1'b0;
        unique case (phase_r)
            eeprom_front_pkg::ST_SLAVE:   ack_want = addr_match;
            eeprom_front_pkg::ST_ADDR_HI: ack_want = 1'b1;
            eeprom_front_pkg::ST_ADDR_LO: ack_want = 1'b1;
            eeprom_front_pkg::ST_WDATA:   ack_want = ~wp_s;
            eeprom_front_pkg::ST_IDLE:    ack_want = 1'b0;
            eeprom_front_pkg::ST_RDATA:   ack_want = 1'b0;
        endcase
    end

    // Phase after the acknowledge slot
    always_comb begin
        phase_nxt = phase_r;
        unique case (phase_r)
            eeprom_front_pkg::ST_SLAVE:
                phase_nxt = addr_match ? (is_read ? eeprom_front_pkg::ST_RDATA
                                                  : eeprom_front_pkg::ST_ADDR_HI)
                                       : eeprom_front_pkg::ST_IDLE;
            eeprom_front_pkg::ST_ADDR_HI: phase_nxt = eeprom_front_pkg::ST_ADDR_LO;
            eeprom_front_pkg::ST_ADDR_LO: phase_nxt = eeprom_front_pkg::ST_WDATA;
            eeprom_front_pkg::ST_WDATA:
                phase_nxt = wp_s ? eeprom_front_pkg::ST_IDLE : eeprom_front_pkg::ST_WDATA;
            eeprom_front_pkg::ST_RDATA:
                phase_nxt = mack_r ? eeprom_front_pkg::ST_RDATA : eeprom_front_pkg::ST_IDLE;
            eeprom_front_pkg::ST_IDLE:    phase_nxt = eeprom_front_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer on the sampled serial clock
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_r   <= eeprom_front_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            ack_r     <= 1'b0;
            tx_r      <= 1'b0;
            mack_r    <= 1'b0;
        end else if (start_det) begin
            phase_r   <= busy ? eeprom_front_pkg::ST_IDLE
                              : eeprom_front_pkg::ST_SLAVE;
            bit_cnt_r <= 4'h0;
            ack_r     <= 1'b0;
            tx_r      <= 1'b0;
        end else if (stop_det) begin
            phase_r   <= eeprom_front_pkg::ST_IDLE;
            ack_r     <= 1'b0;
            tx_r      <= 1'b0;
        end else if (phase_r != eeprom_front_pkg::ST_IDLE) begin
            // A read byte must not move on the rise, or the pin changes in clock high
            if (scl_rise && rx_phase && bit_cnt_r < eeprom_front_pkg::BITS_PER_BYTE) begin
                shift_r <= {shift_r[6:0], sda_s};
            end
            if (scl_rise && bit_cnt_r == eeprom_front_pkg::ACK_SLOT) begin
                mack_r <= ~sda_s;
            end
            // Counting rises keeps the start's own clock fall out of the byte
            if (scl_rise && bit_cnt_r <= eeprom_front_pkg::ACK_SLOT) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (slot_done) begin
                bit_cnt_r <= 4'h0;
            end
            if (byte_done && rx_phase) begin
                ack_r <= ack_want;
            end
            if (slot_done) begin
                ack_r   <= 1'b0;
                phase_r <= phase_nxt;
                tx_r    <= (phase_nxt == eeprom_front_pkg::ST_RDATA);
                shift_r <= i_rd_data;
            end else if (byte_done && phase_r == eeprom_front_pkg::ST_RDATA) begin
                tx_r <= 1'b0;
            end else if (scl_fall && tx_r) begin
                shift_r <= {shift_r[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address, write capture and busy timer
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_r     <= '0;
            hi_r       <= 8'h00;
            wr_r       <= '0;
            pend_r     <= 1'b0;
            busy_cnt_r <= 32'h0;
        end else begin
            wr_r.valid <= 1'b0;
            if (busy_cnt_r != 32'h0) begin
                busy_cnt_r <= busy_cnt_r - 32'h1;
            end
            if (start_det) begin
                pend_r <= 1'b0;
            end
            if (byte_done && phase_r == eeprom_front_pkg::ST_ADDR_HI) begin
                hi_r <= rx_byte;
            end
            if (byte_done && phase_r == eeprom_front_pkg::ST_ADDR_LO) begin
                addr_r <= {hi_r[eeprom_front_pkg::HI_USED_BITS-1:0], rx_byte};
            end
            if (byte_done && phase_r == eeprom_front_pkg::ST_WDATA && !wp_s) begin
                wr_r.addr  <= addr_r;
                wr_r.data  <= rx_byte;
                pend_r     <= 1'b1;
            end
            // Step during the master's acknowledge so slot end loads the next byte
            if (byte_done && phase_r == eeprom_front_pkg::ST_RDATA) begin
                addr_r <= addr_r + 14'h0001;
            end
            if (stop_det && pend_r) begin
                wr_r.valid <= 1'b1;
                pend_r     <= 1'b0;
                busy_cnt_r <= 32'(WR_CYCLES);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain pin: only ever pulls low
    wire drive_low = ack_r | (tx_r & ~shift_r[7]);
    assign o_sda_o     = 1'b0;
    assign o_sda_oe    = drive_low & ~busy;
    assign o_addr      = wr_r.valid ? wr_r.addr : addr_r;
    assign o_wr_data   = wr_r.data;
    assign o_wr_strobe = wr_r.valid;
    assign o_busy      = busy;
    assign o_selected  = phase_r != eeprom_front_pkg::ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr_stop;
        stop_det && pend_r;
    endsequence

    a_sda_never_high: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        o_sda_oe |-> !o_sda_o) else $error("data pin driven high");
    a_busy_no_ack: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        busy |-> !o_sda_oe) else $error("drive while busy");
    a_stop_idles: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        stop_det |=> phase_r == eeprom_front_pkg::ST_IDLE) else $error("stop ignored");
    a_start_arms: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        start_det && !busy |=> phase_r == eeprom_front_pkg::ST_SLAVE && bit_cnt_r == 4'h0)
        else $error("start missed");
    a_wr_then_busy: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_wr_stop |=> o_wr_strobe ##1 !o_wr_strobe && busy) else $error("write start");
    a_mismatch_idle: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        slot_done && phase_r == eeprom_front_pkg::ST_SLAVE && !addr_match
        |=> phase_r == eeprom_front_pkg::ST_IDLE) else $error("mismatch not idle");
    a_wp_no_ack: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        byte_done && phase_r == eeprom_front_pkg::ST_WDATA && wp_s
        |=> !ack_r) else $error("ack under protect");
    a_ack_released: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        slot_done && !start_det && !stop_det |=> !ack_r) else $error("ack held");
    a_cnt_bound: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        bit_cnt_r <= eeprom_front_pkg::ACK_SLOT + 4'h1) else $error("bit count overrun");

    sequence s_addr_byte_in;
        byte_done && (phase_r == eeprom_front_pkg::ST_ADDR_HI
                      || phase_r == eeprom_front_pkg::ST_ADDR_LO);
    endsequence
    sequence s_foreign_slave;
        byte_done && phase_r == eeprom_front_pkg::ST_SLAVE && !(type_ok && unit_ok);
    endsequence

    a_sda_hold_high: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        scl_s && scl_d_r |-> $stable(o_sda_oe))
        else $error("data line moved while clock high");
    a_addr_acked: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_addr_byte_in |=> o_sda_oe [*4])
        else $error("address byte not acknowledged");
    a_rd_release: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        byte_done && phase_r == eeprom_front_pkg::ST_RDATA |=> !o_sda_oe)
        else $error("read byte not released for acknowledge");
    a_foreign_no_ack: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        s_foreign_slave |=> (!o_sda_oe) [*4])
        else $error("foreign address acknowledged");
endmodule
`default_nettype wire

// *** bench/bus_master_model.sv ***
// Behavioural two-wire bus master driving the front end's bus pins
`default_nettype none
module bus_master_model (
    // Clock and bus
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus clock stands high outside frames, one period is 8 system clocks
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic wait_q(input int n);
        repeat (2 * n) @(negedge i_sys_clk);
    endtask
    // Data moves only with the clock low; sampled late in the high phase
    task automatic clk_bit(input logic val, output logic seen);
        wait_q(1);
        o_sda_oe = !val;
        wait_q(1);
        o_scl = 1'b1;
        wait_q(2);
        seen = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic start();
        wait_q(2);
        o_sda_oe = 1'b0;
        wait_q(1);
        o_scl = 1'b1;
        wait_q(2);
        o_sda_oe = 1'b1;
        wait_q(2);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        wait_q(1);
        o_sda_oe = 1'b1;
        wait_q(1);
        o_scl = 1'b1;
        wait_q(2);
        o_sda_oe = 1'b0;
        wait_q(2);
    endtask
    // Releases the line in the ninth clock so the receiver can answer
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], s);
        end
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // Acknowledges to continue, withholds to end the read
    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(!ack, s);
    endtask
endmodule
`default_nettype wire

// *** bench/tb_eeprom_front.sv ***
// Self-checking bench for the two-wire EEPROM slave front end
`default_nettype none
module tb_eeprom_front;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR_CYC = 200;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  straps = 3'h0;
    logic        wp = 1'b0;
    logic        scl, m_oe, sda_o, sda_oe, wr_strobe, busy, sel, sda, ack;
    logic [eeprom_front_pkg::ADDR_BITS-1:0] addr, st_addr, a;
    logic [7:0]  wr_data, rd_data, st_data, hi, lo, d, b;
    int          error_cnt = 0;
    int          comparisons = 0;
    int          strobes = 0;
    int          n;
    function automatic logic [7:0] mem_of(input logic [13:0] x);
        return x[7:0] ^ {2'h0, x[13:8]} ^ 8'h3C;
    endfunction
    // Pull-up on the data line; any driver pulls it low
    assign sda = (m_oe || sda_oe) ? 1'b0 : 1'b1;
    assign rd_data = mem_of(addr);
    always #2 sys_clk = ~sys_clk;
    bus_master_model m (.i_sys_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    eeprom_front #(.WR_CYCLES(WR_CYC)) dut (
        .i_sys_clk(sys_clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .i_unit_select_strap_hi(straps[2]), .i_unit_select_strap_mid(straps[1]),
        .i_unit_select_strap_lo(straps[0]), .i_write_protect(wp),
        .i_rd_data(rd_data), .o_addr(addr), .o_wr_data(wr_data),
        .o_wr_strobe(wr_strobe), .o_busy(busy), .o_selected(sel));
    always @(posedge sys_clk) begin
        if (wr_strobe === 1'b1) begin
            strobes <= strobes + 1;
            st_addr <= addr;
            st_data <= wr_data;
        end
        if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
            error_cnt++;
            $display("unexpected sda_o: expected 0, seen %b", sda_o);
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] sb(input logic rd);
        return {eeprom_front_pkg::TYPE_CODE, straps, rd};
    endfunction
    task automatic send(input logic [7:0] v, input logic exp_ack);
        m.write_byte(v, ack);
        check("ack", 16'(exp_ack), 16'(ack));
    endtask
    task automatic set_addr(input logic [7:0] h, input logic [7:0] l);
        m.start();
        send(sb(1'b0), 1'b1);
        send(h, 1'b1);
        send(l, 1'b1);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the expected run of about 16 us
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        void'($urandom(32'h66bc9d39));
        repeat (4) @(negedge sys_clk);
        check("reset outputs", 16'h0, {addr, sda_oe, busy});
        check("reset flags", 16'h0, 16'({sel, wr_strobe}));
        nrst = 1'b1;
        repeat (4) @(negedge sys_clk);
        send(sb(1'b0), 1'b0);
        check("selected", 16'h0, 16'(sel));
        for (int s = 0; s < 8; s++) begin
            straps = 3'(s);
            m.start();
            send(sb(1'b0), 1'b1);
            check("selected", 16'h1, 16'(sel));
            m.stop();
            repeat (4) @(negedge sys_clk);
            check("selected", 16'h0, 16'(sel));
            m.start();
            send(sb(1'b0) ^ (8'h2 << $urandom_range(2, 0)), 1'b0);
            m.start();
            d = 8'($urandom());
            if (d[7:4] == eeprom_front_pkg::TYPE_CODE) d[7] = ~d[7];
            send({d[7:4], straps, d[0]}, 1'b0);
            m.stop();
        end
        // Upper address bits set on purpose; they must be dropped
        hi = 8'($urandom()) | 8'hC0;
        lo = 8'($urandom());
        d = 8'($urandom());
        set_addr(hi, lo);
        send(d, 1'b1);
        n = strobes;
        m.stop();
        for (int i = 0; i < 100 && strobes == n; i++) @(negedge sys_clk);
        check("strobes", 16'(n + 1), 16'(strobes));
        check("write addr", {2'h0, hi[5:0], lo}, 16'(st_addr));
        check("write data", 16'(d), 16'(st_data));
        check("busy", 16'h1, 16'(busy));
        m.start();
        send(sb(1'b0), 1'b0);
        m.stop();
        for (int i = 0; i < 400 && busy === 1'b1; i++) @(negedge sys_clk);
        check("busy", 16'h0, 16'(busy));
        m.start();
        send(sb(1'b0), 1'b1);
        m.stop();
        wp = 1'b1;
        set_addr(8'($urandom()), 8'($urandom()));
        send(8'($urandom()), 1'b0);
        n = strobes;
        m.stop();
        repeat (40) @(negedge sys_clk);
        check("strobes", 16'(n), 16'(strobes));
        check("busy", 16'h0, 16'(busy));
        wp = 1'b0;
        // Random read: dummy write of the address, then repeated start
        a = 14'($urandom());
        set_addr({2'h0, a[13:8]}, a[7:0]);
        m.start();
        send(sb(1'b1), 1'b1);
        for (int k = 0; k < 3; k++) begin
            m.read_byte(k < 2, b);
            check("read data", 16'(mem_of(a + 14'(k))), 16'(b));
        end
        m.stop();
        repeat (8) @(negedge sys_clk);
        check("selected", 16'h0, 16'(sel));
        wrap_up();
    end
endmodule
`default_nettype wire
